/* File: refclk_tune_defs.vh */
// Register map, field positions and reset values of the clock-control block.
// Assumes a 32-bit APB slave with byte addresses; registers sit in data bits 15:0.
`ifndef REFCLK_TUNE_DEFS_VH
`define REFCLK_TUNE_DEFS_VH

// Register byte offsets.
`define OFS_TRIM 8'h00
`define OFS_REFCTL 8'h04
`define OFS_DISPDIV 8'h08
`define OFS_DISPBR 8'h0c
`define OFS_STATUS 8'h10

// Trim register fields.
`define TRIM_MSB 5
`define TRIM_RST 6'h00

// Reference output control fields.
`define REF_EN_BIT 15
`define REF_SLP_BIT 13
`define REF_SEL_BIT 12
`define REF_DIV_MSB 11
`define REF_DIV_LSB 8
`define REF_RST 4'h0

// Display divider fields.
`define DISP_DIV_MSB 15
`define DISP_DIV_LSB 9
`define DISP_DIV_RST 7'h00
`define DISP_BR_BIT 0
`define DISP_BR_RST 1'b0

// Display divisor in quarter steps: segment bases and segment starts.
`define DISP_SEG2_CODE 7'h40
`define DISP_SEG3_CODE 7'h60
`define DISP_Q_BASE1 9'h004
`define DISP_Q_BASE2 9'h044
`define DISP_Q_BASE3 9'h084
`define DISP_Q_STEP 9'h004

// Primary submode and source codes.
`define SUB_EC 2'h0
`define SUB_XT 2'h1
`define SUB_HS 2'h2
`define SRC_PRI 3'h2
`define SRC_PRI_PLL 3'h3

// Decoded primary modes reported in the status register.
`define MODE_NONE 3'h0
`define MODE_EC 3'h1
`define MODE_EXTERNAL_CLOCK_PLL_MODE 3'h2
`define MODE_HS 3'h3
`define MODE_FAST_CRYSTAL_PLL_MODE 3'h4
`define MODE_XT 3'h5
`define MODE_MEDIUM_CRYSTAL_PLL_MODE 3'h6

`endif

/* File: pow2_tick_divider.v */
// Power-of-two divider of a one-cycle tick stream.
// Assumes ticks are single sys_clk cycles; a new ratio is taken only at a period end or while stopped.
`timescale 1ns/1ps
module pow2_tick_divider #(
  parameter SHIFT_W = 4,
  parameter CNT_W = 15
)
(
  input wire sys_clk,
  input wire srst,
  input wire run,
  input wire tick,
  input wire [SHIFT_W-1:0] shift,
  output reg pulse_r
);
  // Ratio in use for the current period.
  reg [SHIFT_W-1:0] cur_shift_r;
  // Ticks counted in the current period.
  reg [CNT_W-1:0] cnt_r;
  // Last count of a period for the ratio in use.
  wire [CNT_W-1:0] last_cnt;

  assign last_cnt = ({{(CNT_W-1){1'b0}}, 1'b1} << cur_shift_r) - {{(CNT_W-1){1'b0}}, 1'b1};

  // Count ticks and emit one pulse per period; the ratio reloads only at the
  // period boundary or while stopped, so a change never produces a runt period.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      cnt_r <= {CNT_W{1'b0}};
      cur_shift_r <= {SHIFT_W{1'b0}};
      pulse_r <= 1'b0;
    end
    else if (!run)
    begin
      // Stopped: hold at the start of a period and follow the setting.
      cnt_r <= {CNT_W{1'b0}};
      cur_shift_r <= shift;
      pulse_r <= 1'b0;
    end
    else if (tick)
    begin
      if (cnt_r >= last_cnt)
      begin
        // End of period: pulse and take the new ratio.
        cnt_r <= {CNT_W{1'b0}};
        cur_shift_r <= shift;
        pulse_r <= 1'b1;
      end
      else
      begin
        // Inside the period.
        cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
        pulse_r <= 1'b0;
      end
    end
    else
    begin
      // No tick this cycle.
      pulse_r <= 1'b0;
    end
  end
endmodule // pow2_tick_divider

/* File: refclk_tune_display_system_clock_divider.v */
// Clock-control block: oscillator trim, reference clock output, display clock
// fractional divider and primary oscillator mode decode, behind an APB slave.
// Assumes all base clocks arrive as one-cycle tick enables synchronous to sys_clk.
`timescale 1ns/1ps
`include "refclk_tune_defs.vh"

module refclk_tune_display_system_clock_divider #(
  parameter REF_DIV_W = 4,
  parameter REF_CNT_W = 15,
  parameter DISP_CODE_W = 7
)
(
  input wire sys_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire sys_clk_tick,
  input wire primary_osc_tick,
  input wire pll96_tick,
  input wire pll48_tick,
  input wire pll96_en,
  input wire sleep_active,
  input wire [1:0] primary_submode_cfg,
  input wire [2:0] initial_source_cfg,
  input wire [2:0] current_source_status,
  output reg [5:0] trim_code,
  output reg refclk_pin,
  output reg display_clk_tick,
  output reg primary_osc_out_pin,
  output reg primary_osc_out_oe
);
  // Software-visible control fields.
  reg [5:0] trim_code_r;
  reg refclk_out_en_r;
  reg refclk_sleep_run_r;
  reg refclk_source_sel_r;
  reg [REF_DIV_W-1:0] refclk_divisor_r;
  reg [DISP_CODE_W-1:0] display_divisor_code_r;
  reg display_branch_sel_r;
  // Source currently feeding the reference divider.
  reg ref_src_cur_r;
  // Decoded primary mode and running-on-primary flag.
  reg [2:0] primary_mode_r;
  reg on_primary_r;
  // Display divider state: divisor in use and dither accumulator.
  reg [8:0] disp_q_cur_r;
  reg [8:0] disp_acc_r;
  reg disp_branch_cur_r;
  // Bus decode and read mux.
  wire apb_access;
  wire apb_done;
  reg [15:0] rd_word;
  reg addr_hit;
  // Reference path wires.
  wire ref_run;
  wire ref_base_tick;
  wire ref_pulse;
  // Display path wires.
  reg [8:0] disp_q_nxt;
  wire disp_in_tick;
  wire [8:0] disp_acc_sum;

  // A request is taken at the edge where the access phase sees pready high.
  assign apb_access = psel & penable;
  assign apb_done = apb_access & pready;

  // Register read mux; unimplemented bits stay zero.
  always @*
  begin
    rd_word = 16'h0000;
    addr_hit = 1'b1;
    case (paddr)
      `OFS_TRIM:
      begin
        rd_word[`TRIM_MSB:0] = trim_code_r;
      end
      `OFS_REFCTL:
      begin
        rd_word[`REF_EN_BIT] = refclk_out_en_r;
        rd_word[`REF_SLP_BIT] = refclk_sleep_run_r;
        rd_word[`REF_SEL_BIT] = refclk_source_sel_r;
        rd_word[`REF_DIV_MSB:`REF_DIV_LSB] = refclk_divisor_r;
      end
      `OFS_DISPDIV:
      begin
        // Only the divisor field is implemented.
        rd_word[`DISP_DIV_MSB:`DISP_DIV_LSB] = display_divisor_code_r;
      end
      `OFS_DISPBR:
      begin
        // Display branch select.
        rd_word[`DISP_BR_BIT] = display_branch_sel_r;
      end
      `OFS_STATUS:
      begin
        // Live state: running on primary, decoded mode, PLL enable.
        rd_word[0] = on_primary_r;
        rd_word[3:1] = primary_mode_r;
        rd_word[4] = pll96_en;
      end
      default:
      begin
        // Unmapped address answers with an error.
        addr_hit = 1'b0;
      end
    endcase
  end

  // APB slave: one wait state, then pready with data or error for one cycle.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (apb_access && !pready)
    begin
      // Answer in the second access cycle.
      pready <= 1'b1;
      pslverr <= ~addr_hit;
      prdata <= (!pwrite && addr_hit) ? {16'h0000, rd_word} : 32'h00000000;
    end
    else
    begin
      // Release after the completing edge.
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // Register writes take effect only at the completing edge.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      trim_code_r <= `TRIM_RST;
      refclk_out_en_r <= 1'b0;
      refclk_sleep_run_r <= 1'b0;
      refclk_source_sel_r <= 1'b0;
      refclk_divisor_r <= `REF_RST;
      display_divisor_code_r <= `DISP_DIV_RST;
      display_branch_sel_r <= `DISP_BR_RST;
    end
    else if (apb_done && pwrite && addr_hit)
    begin
      case (paddr)
        `OFS_TRIM:
        begin
          trim_code_r <= pwdata[`TRIM_MSB:0];
        end
        `OFS_REFCTL:
        begin
          // Reference control fields.
          refclk_out_en_r <= pwdata[`REF_EN_BIT];
          refclk_sleep_run_r <= pwdata[`REF_SLP_BIT];
          refclk_source_sel_r <= pwdata[`REF_SEL_BIT];
          refclk_divisor_r <= pwdata[`REF_DIV_MSB:`REF_DIV_LSB];
        end
        `OFS_DISPDIV:
        begin
          // Display divisor code.
          display_divisor_code_r <= pwdata[`DISP_DIV_MSB:`DISP_DIV_LSB];
        end
        `OFS_DISPBR:
        begin
          // Display branch select.
          display_branch_sel_r <= pwdata[`DISP_BR_BIT];
        end
        default:
        begin
          // Status is read-only.
          trim_code_r <= trim_code_r;
        end
      endcase
    end
  end

  // The trim code goes to the oscillator as a two's complement value.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      trim_code <= `TRIM_RST;
    end
    else
    begin
      trim_code <= trim_code_r;
    end
  end

  assign ref_run = refclk_out_en_r &
    ~(sleep_active & ref_src_cur_r & ~refclk_sleep_run_r);
  assign ref_base_tick = ref_src_cur_r ? primary_osc_tick : sys_clk_tick;

  // The source choice is taken only at a period end or while stopped.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      ref_src_cur_r <= 1'b0;
    end
    else if (ref_pulse || !ref_run)
    begin
      ref_src_cur_r <= refclk_source_sel_r;
    end
  end

  // divide by two to the code
  pow2_tick_divider #(
    .SHIFT_W(REF_DIV_W),
    .CNT_W(REF_CNT_W)
  ) pow2_tick_divider_inst (
    .sys_clk(sys_clk),
    .srst(srst),
    .run(ref_run),
    .tick(ref_base_tick),
    .shift(refclk_divisor_r),
    .pulse_r(ref_pulse)
  );

  // Reference pin carries one pulse per divided period while ref_run is high (enabled and not stopped by sleep).
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      refclk_pin <= 1'b0;
    end
    else
    begin
      refclk_pin <= ref_pulse & ref_run;
    end
  end

  // Divisor in quarter steps from the code.
  always @*
  begin
    disp_q_nxt = `DISP_Q_BASE1;
    if (display_divisor_code_r >= `DISP_SEG3_CODE)
    begin
      // 33 plus one per step
      // The low five bits already count steps from the segment start,
      // so no subtraction of the segment code is needed.
      disp_q_nxt = `DISP_Q_BASE3 + {2'b00, display_divisor_code_r[4:0], 2'b00};
    end
    else if (display_divisor_code_r >= `DISP_SEG2_CODE)
    begin
      disp_q_nxt = `DISP_Q_BASE2 + {3'b000, display_divisor_code_r[4:0], 1'b0};
    end
    else
    begin
      disp_q_nxt = `DISP_Q_BASE1 + {3'b000, display_divisor_code_r[5:0]};
    end
  end

  // branch select picks 96 or 48
  // 48 MHz ticks come half as often
  assign disp_in_tick = disp_branch_cur_r ? pll96_tick : pll48_tick;
  assign disp_acc_sum = disp_acc_r + `DISP_Q_STEP;

  // Fractional divider: each input tick adds four quarters; a pulse is issued
  // when the sum reaches the divisor, and the remainder carries over.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      disp_acc_r <= 9'h000;
      disp_q_cur_r <= `DISP_Q_BASE1;
      disp_branch_cur_r <= `DISP_BR_RST;
      display_clk_tick <= 1'b0;
    end
    else if (!pll96_en)
    begin
      disp_acc_r <= 9'h000;
      disp_q_cur_r <= disp_q_nxt;
      disp_branch_cur_r <= display_branch_sel_r;
      display_clk_tick <= 1'b0;
    end
    else if (disp_in_tick)
    begin
      if (disp_acc_sum >= disp_q_cur_r)
      begin
        disp_acc_r <= disp_acc_sum - disp_q_cur_r;
        disp_q_cur_r <= disp_q_nxt;
        disp_branch_cur_r <= display_branch_sel_r;
        display_clk_tick <= 1'b1;
      end
      else
      begin
        // Still inside the output period.
        disp_acc_r <= disp_acc_sum;
        display_clk_tick <= 1'b0;
      end
    end
    else
    begin
      // No input tick this cycle.
      display_clk_tick <= 1'b0;
    end
  end

  // Decode the primary mode from the configuration bits.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      primary_mode_r <= `MODE_NONE;
      on_primary_r <= 1'b0;
    end
    else
    begin
      on_primary_r <= (current_source_status == `SRC_PRI) ||
        (current_source_status == `SRC_PRI_PLL);
      case (primary_submode_cfg)
        `SUB_EC:
        begin
          // External clock input.
          primary_mode_r <= (initial_source_cfg == `SRC_PRI_PLL) ?
            `MODE_EXTERNAL_CLOCK_PLL_MODE : `MODE_EC;
        end
        `SUB_XT:
        begin
          // Medium crystal.
          primary_mode_r <= (initial_source_cfg == `SRC_PRI_PLL) ?
            `MODE_MEDIUM_CRYSTAL_PLL_MODE : `MODE_XT;
        end
        `SUB_HS:
        begin
          // Fast crystal.
          primary_mode_r <= (initial_source_cfg == `SRC_PRI_PLL) ?
            `MODE_FAST_CRYSTAL_PLL_MODE : `MODE_HS;
        end
        default:
        begin
          // Primary oscillator off.
          primary_mode_r <= `MODE_NONE;
        end
      endcase
    end
  end

  // In plain external clock mode the second pin outputs Fosc/2.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      primary_osc_out_pin <= 1'b0;
      primary_osc_out_oe <= 1'b0;
    end
    else if (primary_mode_r == `MODE_EC)
    begin
      primary_osc_out_oe <= 1'b1;
      if (primary_osc_tick)
      begin
        primary_osc_out_pin <= ~primary_osc_out_pin;
      end
    end
    else
    begin
      // Pin left to the crystal or other use.
      primary_osc_out_oe <= 1'b0;
      primary_osc_out_pin <= 1'b0;
    end
  end
endmodule // refclk_tune_display_system_clock_divider

/* File: refclk_tune_monitor.sv */
// Checker for the clock-control block; it watches only the block's ports.
// Assumes the register map of refclk_tune_defs.vh and a one-wait APB slave.
`timescale 1ns/1ps
`include "refclk_tune_defs.vh"
module refclk_tune_monitor (
  input wire sys_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire pll96_en,
  input wire sleep_active,
  input wire primary_osc_tick,
  input wire [1:0] primary_submode_cfg,
  input wire [2:0] initial_source_cfg,
  input wire [5:0] trim_code,
  input wire refclk_pin,
  input wire display_clk_tick,
  input wire primary_osc_out_pin,
  input wire primary_osc_out_oe
);
  // A completed transfer and a completed write.
  wire done = psel & penable & pready;
  wire wr = done & pwrite;
  // Shadow copy of the reference enable, source and sleep-run fields.
  reg en_r, sel_r, slp_r;
  // Cycles the reference output has been stopped, saturating at three.
  reg [1:0] stop_cnt_r;
  wire stop = !en_r || (sleep_active && sel_r && !slp_r);
  // Follow reference control writes and count the stopped span.
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      en_r <= 1'b0;
      sel_r <= 1'b0;
      slp_r <= 1'b0;
      stop_cnt_r <= 2'h0;
    end
    else
    begin
      if (wr && paddr == `OFS_REFCTL)
      begin
        en_r <= pwdata[15];
        slp_r <= pwdata[13];
        sel_r <= pwdata[12];
      end
      stop_cnt_r <= !stop ? 2'h0 : ((stop_cnt_r == 2'h3) ? 2'h3 : stop_cnt_r + 2'h1);
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // Setup phase, then exactly one wait before the answer.
  sequence setup_s; psel && !penable; endsequence
  sequence answer_s; !pready ##1 pready; endsequence
  a_one_wait: assert property (setup_s |=> answer_s)
    else $error("answer not after exactly one wait");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_idle_quiet: assert property (!pready |-> (prdata == 32'h0) && !pslverr)
    else $error("read data or error outside answer");
  a_unmapped_err: assert property (done |-> pslverr == !(paddr[1:0] == 2'h0 && paddr <= 8'h10))
    else $error("error flag does not match address");
  a_trim_follows: assert property (wr && paddr == `OFS_TRIM |->
    ##2 trim_code == $past(pwdata[5:0], 2))
    else $error("trim output does not follow write");
  a_trim_upper_zero: assert property (done && !pwrite && paddr == `OFS_TRIM |->
    prdata[31:6] == 0)
    else $error("trim upper bits not zero");
  a_refctl_holes: assert property (done && !pwrite && paddr == `OFS_REFCTL |->
    !prdata[14] && prdata[7:0] == 8'h00)
    else $error("reference control holes not zero");
  a_ref_stopped: assert property (stop_cnt_r == 2'h3 |-> !refclk_pin)
    else $error("reference output runs while stopped");
  a_disp_no_pll: assert property (!pll96_en && !$past(pll96_en) &&
    !$past(pll96_en, 2) |-> !display_clk_tick)
    else $error("display clock runs without the PLL");
  // The mode is decoded one edge after the inputs and the enable follows one edge later.
  a_oe_mode: assert property ($past(primary_submode_cfg, 2) != 2'h0 ||
    $past(initial_source_cfg, 2) == 3'h3 |-> !primary_osc_out_oe)
    else $error("clock out enabled outside external clock mode");
  a_pin_toggle: assert property ($past(primary_osc_out_oe) && primary_osc_out_oe |->
    (primary_osc_out_pin != $past(primary_osc_out_pin)) == $past(primary_osc_tick))
    else $error("clock out pin not toggling per primary tick");
endmodule // refclk_tune_monitor

/* File: pulse_sink_model.sv */
// Far-side device clocked by a pulse stream; it logs each arrival.
// Assumes one-cycle pulses synchronous to sys_clk.
`timescale 1ns/1ps
module pulse_sink_model (
  input wire sys_clk,
  input wire pulse,
  output int cnt,
  output int stamp
);
  // Free-running cycle count used to time arrivals.
  int now;
  // Count each pulse and keep the cycle it came in.
  always @(posedge sys_clk)
  begin
    now <= now + 1;
    if (pulse === 1'b1)
    begin
      cnt <= cnt + 1;
      stamp <= now;
    end
  end
endmodule // pulse_sink_model

/* File: refclk_tune_display_system_clock_divider_tb.sv */
// Self-checking bench for the clock-control block.
// Assumes a one-wait APB slave; base clock ticks are made here.
`timescale 1ns/1ps
module refclk_tune_display_system_clock_divider_tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic e;} row_t;
  logic sys_clk = 1'h0;
  logic srst = 1'h1;
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sys_clk_tick = 1'h0, primary_osc_tick = 1'h0, pll96_tick = 1'h0, pll48_tick = 1'h0;
  logic pll96_en = 1'h0, sleep_active = 1'h0;
  logic [1:0] primary_submode_cfg = 2'h3;
  logic [2:0] initial_source_cfg = 3'h0, current_source_status = 3'h0;
  wire [31:0] prdata;
  wire [5:0] trim_code;
  wire pready, pslverr, refclk_pin, display_clk_tick, primary_osc_out_pin, primary_osc_out_oe;
  int bad_count, n_tests, rcnt, rstamp, dcnt, dstamp, c;
  logic [31:0] cyc = 32'h0, rd;
  logic [1:0] ph = 2'h0;
  logic er;
  // Ordinary register cases: address, write data, read-back, error.
  // Several trim codes are tried in turn, as software must search them.
  row_t rows [7] = '{'{8'h00, 32'hffffffff, 32'h3f, 1'h0}, '{8'h00, 32'h20, 32'h20, 1'h0},
    '{8'h00, 32'h1f, 32'h1f, 1'h0}, '{8'h04, 32'hffffffff, 32'hbf00, 1'h0},
    '{8'h08, 32'hffffffff, 32'hfe00, 1'h0}, '{8'h0c, 32'hffffffff, 32'h1, 1'h0},
    '{8'h14, 32'hffffffff, 32'h0, 1'h1}};
  int dl [3] = '{0, 1, 4};
  int codes [7] = '{0, 1, 63, 64, 95, 96, 127};
  int mt [8] = '{1, 2, 5, 6, 3, 4, 0, 0};
  refclk_tune_display_system_clock_divider refclk_tune_display_system_clock_divider_inst (.sys_clk(sys_clk), .srst(srst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sys_clk_tick(sys_clk_tick),
    .primary_osc_tick(primary_osc_tick), .pll96_tick(pll96_tick), .pll48_tick(pll48_tick),
    .pll96_en(pll96_en), .sleep_active(sleep_active), .primary_submode_cfg(primary_submode_cfg),
    .initial_source_cfg(initial_source_cfg), .current_source_status(current_source_status),
    .trim_code(trim_code), .refclk_pin(refclk_pin), .display_clk_tick(display_clk_tick),
    .primary_osc_out_pin(primary_osc_out_pin), .primary_osc_out_oe(primary_osc_out_oe));
  pulse_sink_model ref_sink_inst (.sys_clk(sys_clk), .pulse(refclk_pin), .cnt(rcnt),
    .stamp(rstamp));
  pulse_sink_model disp_sink_inst (.sys_clk(sys_clk), .pulse(display_clk_tick), .cnt(dcnt),
    .stamp(dstamp));
  // 20 MHz clock.
  initial
  begin
    forever #25 sys_clk = ~sys_clk;
  end
  // Ticks: system and 96 MHz every 2 cycles, 48 MHz every 4, primary every 3.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 32'h1;
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    sys_clk_tick <= cyc[0];
    pll96_tick <= cyc[0];
    pll48_tick <= (cyc[1:0] == 2'h3);
    primary_osc_tick <= (ph == 2'h2);
  end
  // Compare a seen value against the expected one.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  // One APB transfer; holds the request until pready is sampled high.
  task apb(input logic [7:0] a, input logic [31:0] d, input logic w);
    int k;
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    k = 0;
    @(posedge sys_clk);
    while (pready !== 1'h1 && k < 20)
    begin
      @(posedge sys_clk);
      k++;
    end
    if (k == 20) bad_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Cycles spanned by n output periods, after two pulses to settle.
  task span(input bit s, input int n, output int cy);
    int c0, s0, k;
    c0 = s ? dcnt : rcnt;
    s0 = 0;
    for (k = 0; k < 6000 && (s ? dcnt : rcnt) < c0 + 2 + n; k++)
    begin
      @(posedge sys_clk);
      if ((s ? dcnt : rcnt) == c0 + 2 && s0 == 0) s0 = s ? dstamp : rstamp;
    end
    if (k == 6000) bad_count++;
    cy = (s ? dstamp : rstamp) - s0;
  endtask
  // No output pulse may arrive for 300 cycles.
  task quiet(input bit s);
    int c0;
    repeat (5) @(posedge sys_clk);
    c0 = s ? dcnt : rcnt;
    repeat (300) @(posedge sys_clk);
    chk(s ? dcnt : rcnt, c0);
  endtask
  // Display divisor in quarter steps.
  function int dq(input int k);
    return (k < 64) ? 4 + k : ((k < 96) ? 68 + 2 * (k - 64) : 132 + 4 * (k - 96));
  endfunction
  // Print the counts and the verdict, then stop.
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Cut a hang short.
  initial
  begin
    repeat (30000) @(posedge sys_clk);
    bad_count++;
    report_and_stop;
  end
  // Main sequence.
  initial
  begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'h0;
    foreach (rows[i])
    begin
      apb(rows[i].a, rows[i].d, 1'h1);
      chk(er, rows[i].e);
      apb(rows[i].a, 32'h0, 1'h0);
      chk(rd, rows[i].q);
      chk(er, rows[i].e);
      if (rows[i].a == 8'h00) chk(trim_code, rows[i].q[5:0]);
    end
    $display("register table done");
    srst <= 1'h1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'h0;
    for (int i = 0; i < 16; i += 4)
    begin
      apb(i[7:0], 32'h0, 1'h0);
      chk(rd, 32'h0);
    end
    $display("reset values done");
    foreach (dl[i])
    begin
      apb(8'h04, 32'h8000 | (dl[i] << 8), 1'h1);
      span(0, 1, c);
      chk(c, 2 << dl[i]);
    end
    apb(8'h04, 32'h9200, 1'h1);
    span(0, 1, c);
    chk(c, 12);
    sleep_active <= 1'h1;
    quiet(0);
    apb(8'h04, 32'hb200, 1'h1);
    span(0, 1, c);
    chk(c, 12);
    apb(8'h04, 32'h8200, 1'h1);
    span(0, 1, c);
    chk(c, 8);
    sleep_active <= 1'h0;
    apb(8'h04, 32'h1200, 1'h1);
    quiet(0);
    $display("reference output done");
    pll96_en <= 1'h1;
    apb(8'h0c, 32'h1, 1'h1);
    foreach (codes[i])
    begin
      apb(8'h08, codes[i] << 9, 1'h1);
      span(1, 4, c);
      chk(c, dq(codes[i]) * 2);
    end
    apb(8'h0c, 32'h0, 1'h1);
    span(1, 4, c);
    chk(c, dq(127) * 4);
    pll96_en <= 1'h0;
    quiet(1);
    $display("display divider done");
    for (int m = 0; m < 8; m++)
    begin
      primary_submode_cfg <= m[2:1];
      initial_source_cfg <= m[0] ? 3'h3 : 3'h0;
      current_source_status <= m[2:0];
      apb(8'h10, 32'h0, 1'h0);
      chk(rd, (mt[m] << 1) | (m == 2 || m == 3));
      chk(primary_osc_out_oe, m == 0);
      if (m == 0)
      begin
        // One primary tick falls in any three cycles, so the pin toggles once.
        c = primary_osc_out_pin;
        repeat (3) @(posedge sys_clk);
        chk(primary_osc_out_pin, !c[0]);
      end
    end
    $display("primary mode done");
    report_and_stop;
  end
endmodule // refclk_tune_display_system_clock_divider_tb
bind refclk_tune_display_system_clock_divider refclk_tune_monitor refclk_tune_monitor_inst (.sys_clk(sys_clk),
  .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pll96_en(pll96_en),
  .sleep_active(sleep_active), .primary_osc_tick(primary_osc_tick),
  .primary_submode_cfg(primary_submode_cfg), .initial_source_cfg(initial_source_cfg),
  .trim_code(trim_code), .refclk_pin(refclk_pin), .display_clk_tick(display_clk_tick),
  .primary_osc_out_pin(primary_osc_out_pin), .primary_osc_out_oe(primary_osc_out_oe));
